// ---- rtl/rxdv_device.sv ----
// receive detect device: slicer select, peak detector sequencing, data valid detection, self polling
// Overview of operation
// - config bit 15 selects slicer threshold source
// - peak detector outputs stay active either way
// - peak detectors enabled after receive path active
// - peak outputs forced low and high when off
// - fixed 2.2ms offset compensation after receive start
// - valid needs rate window and level threshold
// - config bits 5,6 pick continuous or single shot
// - detection enable rises 2.6ms after receive start
// - window complete latches level compare, forms valid
// - ready for next conversion after three periods
// - high time measured, single or doubled accepted
// - three data periods observed before decision
// - rate bounds counted in crystal clock over four
// - host writes 12-bit rate bounds at 06h,07h
// - rate bounds reset to zero and one
// - level threshold six bits at 08h
// - level threshold resets to all ones
// - polling intervals 16 bits at 04h,05h
// - valid data while polling pulses wake output
`timescale 1ns/1ps
`include "rxdv_cfg.svh"
module rxdv_device #(
  parameter int OFFCAL_CYCLES = (`RXDV_OFFCAL_NS * `RXDV_CLK_MHZ + 999) / 1000,
  parameter int DETEN_CYCLES = (`RXDV_DETEN_NS * `RXDV_CLK_MHZ + 999) / 1000
) (
  input wire logic CLOCK_I,
  input wire logic RST_I,
  rxdv_if.device BUS,
  input wire logic RX_ON_I,
  input wire logic DATA_I,
  input wire logic [5:0] SSL_I,
  input wire logic RC_TICK_I,
  output logic SLICER_PEAK_O,
  output logic PKD_ENABLE_O,
  output logic PKD_POS_LOW_O,
  output logic PKD_NEG_HIGH_O,
  output logic OFFCAL_O,
  output logic DET_ENABLE_O,
  output logic DATA_VALID_O,
  output logic POLL_ACTIVE_O
);
  localparam logic [17:0] OFFCAL_LAST = 18'(OFFCAL_CYCLES - 1);
  localparam logic [17:0] DETEN_LAST = 18'(DETEN_CYCLES - 1);
  localparam logic [1:0] PRE_LAST = 2'(`RXDV_XTAL_DIV - 1);
  localparam logic [1:0] PER_LAST = 2'(`RXDV_PERIODS - 1);

  rxdv_pkg::dev_state_t s_q;
  rxdv_pkg::dev_state_t s_d;

  function automatic logic in_window(input logic [12:0] t, input logic [12:0] lo, input logic [12:0] hi);
    in_window = (t >= lo) && (t <= hi);
  endfunction : in_window

  logic poll_en;
  logic rxon;
  logic data_now;
  logic data_fall;
  logic tick_rise;
  logic tick4;
  logic [1:0] mode;
  logic mode_on;
  logic rate_hit;
  logic rate_active;
  logic level_ok;
  logic win_done;
  logic new_valid;

  always_comb begin
    s_d = s_q;
    poll_en = s_q.cfg[`RXDV_CFG_POLL_BIT];
    mode = s_q.cfg[`RXDV_CFG_MODE_MSB:`RXDV_CFG_MODE_LSB];
    mode_on = (mode == `RXDV_MODE_CONT) || (mode == `RXDV_MODE_SHOT && !s_q.shot_done);
    // input synchronisers
    s_d.data_s = {s_q.data_s[0], DATA_I};
    s_d.rxon_s = {s_q.rxon_s[0], RX_ON_I};
    s_d.tick_s = {s_q.tick_s[0], RC_TICK_I};
    s_d.ssl_s1 = SSL_I;
    s_d.ssl_s2 = s_q.ssl_s1;
    data_now = s_q.data_s[1];
    s_d.data_d1 = data_now;
    data_fall = s_q.data_d1 && !data_now;
    tick_rise = s_q.tick_s[1] && !s_q.tick_d1;
    s_d.tick_d1 = s_q.tick_s[1];
    // register port
    s_d.wake = 1'b0;
    if (BUS.reg_wr) begin
      case (BUS.reg_addr)
        `RXDV_OFS_CONFIG: s_d.cfg = BUS.reg_wdata;
        `RXDV_OFS_POLL_ON: s_d.poll_on = BUS.reg_wdata;
        `RXDV_OFS_POLL_OFF: s_d.poll_off = BUS.reg_wdata;
        `RXDV_OFS_RATE_LO: s_d.rate_lo = BUS.reg_wdata[`RXDV_RATE_W-1:0];
        `RXDV_OFS_RATE_HI: s_d.rate_hi = BUS.reg_wdata[`RXDV_RATE_W-1:0];
        `RXDV_OFS_LEVEL: s_d.level_th = BUS.reg_wdata[`RXDV_LEVEL_W-1:0];
        default: begin
        end
      endcase
    end
    if (BUS.reg_rd) begin
      case (BUS.reg_addr)
        `RXDV_OFS_CONFIG: s_d.rdata = s_q.cfg;
        `RXDV_OFS_POLL_ON: s_d.rdata = s_q.poll_on;
        `RXDV_OFS_POLL_OFF: s_d.rdata = s_q.poll_off;
        `RXDV_OFS_RATE_LO: s_d.rdata = {4'h0, s_q.rate_lo};
        `RXDV_OFS_RATE_HI: s_d.rdata = {4'h0, s_q.rate_hi};
        `RXDV_OFS_LEVEL: s_d.rdata = {10'h000, s_q.level_th};
        `RXDV_OFS_STATUS: s_d.rdata = {8'h00, s_q.valid, s_q.shot_done, s_q.poll_phase, s_q.det_en,
                                       s_q.offcal, s_q.pkd_en, s_q.seq};
        default: s_d.rdata = 16'h0000;
      endcase
    end
    s_d.slicer_peak = s_q.cfg[`RXDV_CFG_SLICER_BIT];
    // self polling interval counters
    if (!poll_en) begin
      s_d.poll_phase = 1'b1;
      s_d.poll_cnt = s_q.poll_on;
    end else if (tick_rise) begin
      if (s_q.poll_cnt == `RXDV_POLL_TOP) begin
        s_d.poll_phase = !s_q.poll_phase;
        s_d.poll_cnt = s_q.poll_phase ? s_q.poll_off : s_q.poll_on;
      end else begin
        s_d.poll_cnt = s_q.poll_cnt + 16'h0001;
      end
    end
    rxon = s_q.rxon_s[1] || (poll_en && s_q.poll_phase);
    s_d.rxon_d1 = rxon;
    // receive sequencer
    s_d.seq_cnt = s_q.seq_cnt + 18'h0_0001;
    case (s_q.seq)
      rxdv_pkg::SEQ_OFF: begin
        s_d.seq_cnt = 18'h0_0000;
        if (rxon) begin
          s_d.seq = rxdv_pkg::SEQ_OFFCAL;
          s_d.offcal = 1'b1;
        end
      end
      rxdv_pkg::SEQ_OFFCAL: begin
        if (s_q.seq_cnt == OFFCAL_LAST) begin
          s_d.seq = rxdv_pkg::SEQ_SETTLE;
          s_d.offcal = 1'b0;
          s_d.pkd_en = 1'b1;
        end
      end
      rxdv_pkg::SEQ_SETTLE: begin
        if (s_q.seq_cnt == DETEN_LAST) begin
          s_d.seq = rxdv_pkg::SEQ_DETECT;
          s_d.det_en = 1'b1;
        end
      end
      rxdv_pkg::SEQ_DETECT: s_d.seq_cnt = s_q.seq_cnt;
      default: s_d.seq = rxdv_pkg::SEQ_OFF;
    endcase
    // data rate and level detection
    tick4 = (s_q.pre_cnt == PRE_LAST);
    s_d.pre_cnt = tick4 ? 2'h0 : s_q.pre_cnt + 2'h1;
    rate_active = s_q.rate_hi > `RXDV_RATE_OFF_MAX;
    rate_hit = rate_active && (in_window(s_q.high_cnt, {1'b0, s_q.rate_lo}, {1'b0, s_q.rate_hi}) ||
      in_window(s_q.high_cnt, {s_q.rate_lo, 1'b0}, {s_q.rate_hi, 1'b0}));
    level_ok = (s_q.level_th != `RXDV_LEVEL_OFF) && (s_q.ssl_s2 >= s_q.level_th);
    win_done = 1'b0;
    new_valid = 1'b0;
    if (s_q.det_en && mode_on) begin
      if (!data_now) begin
        s_d.high_cnt = 13'h0000;
      end else if (tick4 && s_q.high_cnt != `RXDV_HIGH_MAX) begin
        s_d.high_cnt = s_q.high_cnt + 13'h0001;
      end
      if (data_fall) begin
        s_d.rate_ok_all = s_q.rate_ok_all && rate_hit;
        s_d.period_cnt = s_q.period_cnt + 2'h1;
        if (s_q.period_cnt == PER_LAST) begin
          win_done = 1'b1;
          new_valid = s_q.rate_ok_all && rate_hit && level_ok;
          s_d.valid = new_valid;
          s_d.period_cnt = 2'h0;
          s_d.rate_ok_all = 1'b1;
          s_d.shot_done = (mode == `RXDV_MODE_SHOT);
        end
      end
    end
    s_d.wake = win_done && new_valid && !s_q.valid && poll_en;
    // receive path dropped or restarted: back to idle
    if (!rxon || (rxon && !s_q.rxon_d1 && s_q.seq != rxdv_pkg::SEQ_OFF)) begin
      s_d.seq = rxdv_pkg::SEQ_OFF;
      s_d.seq_cnt = 18'h0_0000;
      s_d.offcal = 1'b0;
      s_d.pkd_en = 1'b0;
      s_d.det_en = 1'b0;
      s_d.valid = 1'b0;
      s_d.shot_done = 1'b0;
      s_d.period_cnt = 2'h0;
      s_d.rate_ok_all = 1'b1;
      s_d.high_cnt = 13'h0000;
    end
    // peak outputs clamped while detectors off
    s_d.pkd_off = !s_d.pkd_en;
  end

  always_ff @(posedge CLOCK_I) begin
    if (RST_I) begin
      s_q <= '0;
      s_q.cfg <= `RXDV_RST_CONFIG;
      s_q.poll_on <= `RXDV_RST_POLL_ON;
      s_q.poll_off <= `RXDV_RST_POLL_OFF;
      s_q.rate_lo <= `RXDV_RST_RATE_LO;
      s_q.rate_hi <= `RXDV_RST_RATE_HI;
      s_q.level_th <= `RXDV_RST_LEVEL;
      s_q.seq <= rxdv_pkg::SEQ_OFF;
      s_q.pkd_off <= 1'b1;
      s_q.rate_ok_all <= 1'b1;
      s_q.poll_phase <= 1'b1;
      s_q.poll_cnt <= `RXDV_RST_POLL_ON;
    end else begin
      s_q <= s_d;
    end
  end

  assign BUS.reg_rdata = s_q.rdata;
  assign BUS.wake_detect_output = s_q.wake;
  assign SLICER_PEAK_O = s_q.slicer_peak;
  assign PKD_ENABLE_O = s_q.pkd_en;
  assign PKD_POS_LOW_O = s_q.pkd_off;
  assign PKD_NEG_HIGH_O = s_q.pkd_off;
  assign OFFCAL_O = s_q.offcal;
  assign DET_ENABLE_O = s_q.det_en;
  assign DATA_VALID_O = s_q.valid;
  assign POLL_ACTIVE_O = s_q.poll_phase;
endmodule : rxdv_device

// ---- common/rxdv_cfg.svh ----
// register map, field positions, reset values and timing figures of the receive detect block
`ifndef RXDV_CFG_SVH
`define RXDV_CFG_SVH
`define RXDV_ADDR_W 8
`define RXDV_DATA_W 16
`define RXDV_OFS_CONFIG 8'h00
`define RXDV_OFS_POLL_ON 8'h04
`define RXDV_OFS_POLL_OFF 8'h05
`define RXDV_OFS_RATE_LO 8'h06
`define RXDV_OFS_RATE_HI 8'h07
`define RXDV_OFS_LEVEL 8'h08
`define RXDV_OFS_STATUS 8'h09
`define RXDV_CFG_SLICER_BIT 15
`define RXDV_CFG_MODE_LSB 5
`define RXDV_CFG_MODE_MSB 6
`define RXDV_CFG_POLL_BIT 4
`define RXDV_MODE_CONT 2'h1
`define RXDV_MODE_SHOT 2'h2
`define RXDV_RST_CONFIG 16'h0000
`define RXDV_RST_POLL_ON 16'hfebf
`define RXDV_RST_POLL_OFF 16'hf37f
`define RXDV_RST_RATE_LO 12'h000
`define RXDV_RST_RATE_HI 12'h001
`define RXDV_RST_LEVEL 6'h3f
`define RXDV_RATE_W 12
`define RXDV_LEVEL_W 6
`define RXDV_RATE_OFF_MAX 12'h001
`define RXDV_LEVEL_OFF 6'h3f
`define RXDV_POLL_TOP 16'hffff
`define RXDV_HIGH_MAX 13'h1fff
`define RXDV_XTAL_DIV 4
`define RXDV_PERIODS 3
`define RXDV_CLK_MHZ 50
`define RXDV_OFFCAL_NS 2200000
`define RXDV_DETEN_NS 2600000
`define RXDV_SEQ_W 18
`endif

// ---- common/rxdv_pkg.sv ----
// types shared by both ends of the receive detect link
`include "rxdv_cfg.svh"
package rxdv_pkg;
  typedef enum logic [1:0] {
    SEQ_OFF = 2'b00,
    SEQ_OFFCAL = 2'b01,
    SEQ_SETTLE = 2'b10,
    SEQ_DETECT = 2'b11
  } seq_state_t;

  typedef struct packed {
    logic [15:0] cfg;
    logic [15:0] poll_on;
    logic [15:0] poll_off;
    logic [11:0] rate_lo;
    logic [11:0] rate_hi;
    logic [5:0] level_th;
    logic [15:0] rdata;
    logic wake;
    logic [1:0] data_s;
    logic [1:0] rxon_s;
    logic [1:0] tick_s;
    logic [5:0] ssl_s1;
    logic [5:0] ssl_s2;
    logic data_d1;
    logic tick_d1;
    logic rxon_d1;
    seq_state_t seq;
    logic [17:0] seq_cnt;
    logic pkd_en;
    logic pkd_off;
    logic offcal;
    logic det_en;
    logic slicer_peak;
    logic [1:0] pre_cnt;
    logic [12:0] high_cnt;
    logic [1:0] period_cnt;
    logic rate_ok_all;
    logic shot_done;
    logic valid;
    logic poll_phase;
    logic [15:0] poll_cnt;
  } dev_state_t;

  typedef struct packed {
    logic [7:0] addr;
    logic [15:0] wdata;
    logic wr;
    logic rd;
    logic rd_d1;
    logic [15:0] rdata;
    logic rvalid;
    logic wake_seen;
  } host_state_t;
endpackage : rxdv_pkg

// ---- common/rxdv_if.sv ----
// register port and wake line between host and receive detect device
`timescale 1ns/1ps
interface rxdv_if;
  logic [7:0] reg_addr;
  logic [15:0] reg_wdata;
  logic reg_wr;
  logic reg_rd;
  logic [15:0] reg_rdata;
  logic wake_detect_output;

  modport device (
    input reg_addr,
    input reg_wdata,
    input reg_wr,
    input reg_rd,
    output reg_rdata,
    output wake_detect_output
  );

  modport host (
    output reg_addr,
    output reg_wdata,
    output reg_wr,
    output reg_rd,
    input reg_rdata,
    input wake_detect_output
  );
endinterface : rxdv_if

// ---- rtl/rxdv_host.sv ----
// host end: drives the register port from user commands and catches wake pulses
`timescale 1ns/1ps
`include "rxdv_cfg.svh"
module rxdv_host (
  input wire logic CLOCK_I,
  input wire logic RST_I,
  rxdv_if.host BUS,
  input wire logic CMD_WR_I,
  input wire logic CMD_RD_I,
  input wire logic [7:0] CMD_ADDR_I,
  input wire logic [15:0] CMD_WDATA_I,
  input wire logic WAKE_ACK_I,
  output logic [15:0] CMD_RDATA_O,
  output logic CMD_RVALID_O,
  output logic WAKE_SEEN_O
);
  rxdv_pkg::host_state_t s_q;
  rxdv_pkg::host_state_t s_d;

  always_comb begin
    s_d = s_q;
    s_d.wr = CMD_WR_I;
    s_d.rd = CMD_RD_I && !CMD_WR_I;
    s_d.addr = CMD_ADDR_I;
    case (CMD_ADDR_I)
      `RXDV_OFS_RATE_LO, `RXDV_OFS_RATE_HI: s_d.wdata = {4'h0, CMD_WDATA_I[`RXDV_RATE_W-1:0]};
      `RXDV_OFS_LEVEL: s_d.wdata = {10'h000, CMD_WDATA_I[`RXDV_LEVEL_W-1:0]};
      default: s_d.wdata = CMD_WDATA_I;
    endcase
    s_d.rd_d1 = s_q.rd;
    s_d.rvalid = s_q.rd_d1;
    if (s_q.rd_d1) begin
      s_d.rdata = BUS.reg_rdata;
    end
    // wake flag: a new pulse wins over the acknowledge
    if (BUS.wake_detect_output) begin
      s_d.wake_seen = 1'b1;
    end else if (WAKE_ACK_I) begin
      s_d.wake_seen = 1'b0;
    end
  end

  always_ff @(posedge CLOCK_I) begin
    if (RST_I) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign BUS.reg_addr = s_q.addr;
  assign BUS.reg_wdata = s_q.wdata;
  assign BUS.reg_wr = s_q.wr;
  assign BUS.reg_rd = s_q.rd;
  assign CMD_RDATA_O = s_q.rdata;
  assign CMD_RVALID_O = s_q.rvalid;
  assign WAKE_SEEN_O = s_q.wake_seen;
endmodule : rxdv_host

// ---- tb/rxdv_assertions.sv ----
// register readback and wake checks on the link
`timescale 1ns/1ps
module rxdv_assertions (
  input wire logic CLOCK_I,
  input wire logic RST_I,
  input wire logic [7:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [15:0] reg_rdata,
  input wire logic wake_detect_output
);
  logic [15:0] cfg_q, on_q, off_q;
  logic [11:0] lo_q, hi_q;
  logic [5:0] lv_q;
  default clocking @(posedge CLOCK_I);
  endclocking
  default disable iff (RST_I);
  always_ff @(posedge CLOCK_I) begin
    if (RST_I) begin
      cfg_q <= 16'h0000;
      on_q <= 16'hfebf;
      off_q <= 16'hf37f;
      lo_q <= 12'h000;
      hi_q <= 12'h001;
      lv_q <= 6'h3f;
    end else if (reg_wr) begin
      case (reg_addr)
        8'h00: cfg_q <= reg_wdata;
        8'h04: on_q <= reg_wdata;
        8'h05: off_q <= reg_wdata;
        8'h06: lo_q <= reg_wdata[11:0];
        8'h07: hi_q <= reg_wdata[11:0];
        8'h08: lv_q <= reg_wdata[5:0];
        default: ;
      endcase
    end
  end
  chk_config_read: assert property (reg_rd && reg_addr == 8'h00 |=> reg_rdata == cfg_q)
    else $error("bad config read");
  chk_active_read: assert property (reg_rd && reg_addr == 8'h04 |=> reg_rdata == on_q)
    else $error("bad active interval read");
  chk_sleep_read: assert property (reg_rd && reg_addr == 8'h05 |=> reg_rdata == off_q)
    else $error("bad sleep interval read");
  chk_low_bound: assert property (reg_rd && reg_addr == 8'h06 |=> reg_rdata == {4'h0, lo_q})
    else $error("bad low bound read");
  chk_high_bound: assert property (reg_rd && reg_addr == 8'h07 |=> reg_rdata == {4'h0, hi_q})
    else $error("bad high bound read");
  chk_level_read: assert property ($past(reg_rd) && $past(reg_addr) == 8'h08 |-> reg_rdata == {10'h000, lv_q})
    else $error("bad level read");
  chk_wake_single: assert property ($rose(wake_detect_output) |=> !wake_detect_output)
    else $error("wake pulse too long");
  chk_wake_mode: assert property (wake_detect_output |-> cfg_q[4] && cfg_q[6:5] inside {2'h1, 2'h2})
    else $error("wake without polling");
  cov_wake: cover property (wake_detect_output);
  cov_level_rd: cover property (reg_rd && reg_addr == 8'h08);
  cov_cfg_wr: cover property (reg_wr && reg_addr == 8'h00);
endmodule : rxdv_assertions

// ---- tb/rx_data_valid_detect_test.sv ----
// self-checking bench joining host and device ends
`timescale 1ns/1ps
module rx_data_valid_detect_test;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic cwr = 1'b0;
  logic crd = 1'b0;
  logic [7:0] cad = 8'h00;
  logic [15:0] cwd = 16'h0000;
  logic ack = 1'b0;
  logic rx_on = 1'b0;
  logic data = 1'b0;
  logic [5:0] ssl = 6'h00;
  logic rc = 1'b0;
  logic [5:0] rc_div = 6'h00;
  logic [15:0] crdata;
  logic rvalid, seen, slicer, pkd, plow, nhigh, offcal, det, valid, pact;
  logic [15:0] mdl [16];
  logic [7:0] al [7] = '{8'h00, 8'h04, 8'h05, 8'h06, 8'h07, 8'h08, 8'h0a};
  int ht [4] = '{24, 48, 80, 8};
  int err_count = 0;
  int compares = 0;
  int rises = 0;
  int n, m, r0;
  rxdv_if bus();
  rxdv_device #(.OFFCAL_CYCLES(20), .DETEN_CYCLES(30)) u_rxdv_device (.CLOCK_I(clk), .RST_I(rst), .BUS(bus),
    .RX_ON_I(rx_on), .DATA_I(data), .SSL_I(ssl), .RC_TICK_I(rc), .SLICER_PEAK_O(slicer), .PKD_ENABLE_O(pkd),
    .PKD_POS_LOW_O(plow), .PKD_NEG_HIGH_O(nhigh), .OFFCAL_O(offcal), .DET_ENABLE_O(det), .DATA_VALID_O(valid),
    .POLL_ACTIVE_O(pact));
  rxdv_host u_rxdv_host (.CLOCK_I(clk), .RST_I(rst), .BUS(bus), .CMD_WR_I(cwr), .CMD_RD_I(crd), .CMD_ADDR_I(cad),
    .CMD_WDATA_I(cwd), .WAKE_ACK_I(ack), .CMD_RDATA_O(crdata), .CMD_RVALID_O(rvalid), .WAKE_SEEN_O(seen));
  rxdv_assertions u_rxdv_assertions (.CLOCK_I(clk), .RST_I(rst), .reg_addr(bus.reg_addr), .reg_wdata(bus.reg_wdata),
    .reg_wr(bus.reg_wr), .reg_rd(bus.reg_rd), .reg_rdata(bus.reg_rdata), .wake_detect_output(bus.wake_detect_output));
  initial forever #10 clk = ~clk;
  always @(posedge clk) begin
    rc_div <= rc_div + 6'h01;
    rc <= rc_div[5];
  end
  always @(posedge rc) rises++;
  task automatic end_sim;
    $display("compares %0d err_count %0d", compares, err_count);
    if (err_count == 0 && compares > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : end_sim
  task automatic chk(string w, logic [15:0] e, logic [15:0] s);
    compares++;
    if (s !== e) begin
      err_count++;
      $display("CHECK FAILED %s exp %h seen %h", w, e, s);
    end
  endtask : chk
  task automatic chb(string w, logic e, logic s);
    chk(w, {15'h0000, e}, {15'h0000, s});
  endtask : chb
  task automatic wait_for(ref logic s, input logic v, input int lim, output int c);
    c = 0;
    while (s !== v) begin
      @(negedge clk);
      c++;
      if (c > lim) begin
        chb("wait", v, s);
        end_sim();
      end
    end
  endtask : wait_for
  function automatic logic [15:0] msk(logic [7:0] a);
    case (a)
      8'h00, 8'h04, 8'h05: return 16'hffff;
      8'h06, 8'h07: return 16'h0fff;
      8'h08: return 16'h003f;
      default: return 16'h0000;
    endcase
  endfunction : msk
  function automatic logic model(int t, logic [5:0] s);
    return ((t >= 4 && t <= 8) || (t >= 8 && t <= 16)) && s >= 6'h14;
  endfunction : model
  task automatic wr(logic [7:0] a, logic [15:0] d);
    cad <= a;
    cwd <= d;
    cwr <= 1'b1;
    @(posedge clk);
    cwr <= 1'b0;
    mdl[a[3:0]] = d & msk(a);
    @(posedge clk);
  endtask : wr
  task automatic rd(logic [7:0] a, logic [15:0] e);
    int c;
    cad <= a;
    crd <= 1'b1;
    @(posedge clk);
    crd <= 1'b0;
    wait_for(rvalid, 1'b1, 10, c);
    chk("rdata", e, crdata);
    @(posedge clk);
  endtask : rd
  task automatic burst(int h, int c);
    repeat (c) begin
      data <= 1'b1;
      repeat (h) @(posedge clk);
      data <= 1'b0;
      repeat (20 + $urandom % 20) @(posedge clk);
    end
  endtask : burst
  initial begin
    void'($urandom(18502));
    foreach (mdl[i]) mdl[i] = 16'h0000;
    mdl[4] = 16'hfebf;
    mdl[5] = 16'hf37f;
    mdl[7] = 16'h0001;
    mdl[8] = 16'h003f;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    foreach (al[i]) rd(al[i], mdl[al[i][3:0]]);
    foreach (al[i]) wr(al[i], 16'($urandom));
    foreach (al[i]) rd(al[i], mdl[al[i][3:0]]);
    chb("slicer", mdl[0][15], slicer);
    wr(8'h06, 16'h0004);
    wr(8'h07, 16'h0008);
    wr(8'h08, 16'h0014);
    wr(8'h00, 16'h8020);
    rx_on <= 1'b1;
    wait_for(offcal, 1'b1, 50, n);
    chb("pkd early", 1'b0, pkd);
    chb("pos low", 1'b1, plow);
    chb("neg high", 1'b1, nhigh);
    wait_for(offcal, 1'b0, 100, n);
    chk("offcal", 16'h0014, 16'(n));
    wait_for(det, 1'b1, 100, m);
    chk("det", 16'h001e, 16'(n + m));
    chb("pkd", 1'b1, pkd);
    chb("pos", 1'b0, plow);
    @(posedge clk);
    for (int i = 0; i < 5; i++) begin
      ssl <= (i == 4) ? 6'($urandom % 20) : 6'(20 + $urandom % 44);
      burst(ht[i % 4], 7);
      repeat (12) @(posedge clk);
      chb("valid", model(ht[i % 4] / 4, ssl), valid);
    end
    rx_on <= 1'b0;
    wr(8'h00, 16'h0040);
    repeat (4) @(posedge clk);
    rx_on <= 1'b1;
    wait_for(det, 1'b1, 200, n);
    chb("pkd lp", 1'b1, pkd);
    chb("slicer lp", 1'b0, slicer);
    @(posedge clk);
    ssl <= 6'h3e;
    burst(24, 7);
    burst(80, 7);
    chb("shot", 1'b1, valid);
    rd(8'h09, 16'h00f7);
    rx_on <= 1'b0;
    wr(8'h04, 16'hffc0);
    wr(8'h05, 16'hfff8);
    wr(8'h00, 16'h0030);
    for (int i = 0; i < 150 && seen !== 1'b1; i++) burst(24, 1);
    chb("wake", 1'b1, seen);
    ack <= 1'b1;
    @(posedge clk);
    ack <= 1'b0;
    repeat (2) @(posedge clk);
    chb("ack", 1'b0, seen);
    wait_for(pact, 1'b0, 9000, n);
    r0 = rises;
    wait_for(pact, 1'b1, 2000, n);
    chk("sleep", 16'h0008, 16'(rises - r0));
    end_sim();
  end
endmodule : rx_data_valid_detect_test
